// [stl_device.sv]
module stl_device (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       powered,
  input  wire logic [1:0] addr_select_pin_a,
  input  wire logic [1:0] addr_select_pin_b,
  input  wire logic       standby,
  input  wire logic [7:0] local_temp,
  input  wire logic [7:0] remote_raw_temp,
  input  wire logic       sensor_open,
  output logic            conv_start,
  output logic            alarm_n,
  output logic [7:0]      status_flags,
  stl_link_if.device      link
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_ADDR = 6'h02, ST_ACK = 6'h04,
    ST_RX   = 6'h08, ST_TX   = 6'h10, ST_SKIP = 6'h20
  } stl_state_type;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_sync_q, sda_sync_q;
  logic       scl_prev_q, sda_prev_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (clk_en) begin
      scl_sync_q <= {scl_sync_q[0], link.scl};
      sda_sync_q <= {sda_sync_q[0], link.serial_data_line};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end
  wire scl_s = scl_sync_q[1];
  wire sda_s = sda_sync_q[1];
  wire scl_rise   = scl_s && !scl_prev_q;
  wire scl_fall   = !scl_s && scl_prev_q;
  wire start_seen = scl_s && scl_prev_q && !sda_s && sda_prev_q; // R11
  wire stop_seen  = scl_s && scl_prev_q && sda_s && !sda_prev_q; // R14

  // ---------------------------------------------------------------
  // registers and protocol state
  // ---------------------------------------------------------------
  stl_state_type state_q, state_d;
  logic [7:0] shift_q, shift_d, ptr_q, ptr_d;
  logic [3:0] bit_q, bit_d;
  logic       read_q, read_d, pend_q, pend_d;
  logic [1:0] nbytes_q, nbytes_d;
  logic [7:0] lim_q [4];
  logic [7:0] lim_d [4];
  logic [7:0] offset_q, offset_d;
  logic [6:0] my_addr_q;
  logic       addr_taken_q;
  logic [1:0] pin_a_s1_q, pin_a_s2_q, pin_b_s1_q, pin_b_s2_q;
  logic [1:0] cap_wait_q;
  logic [3:0] addr_idx;
  logic       sda_drv_q, sda_drv_d;
  logic [4:0] flags_q, flags_d;
  logic       shot_d;
  logic [7:0] rd_data;

  // strap pins pass two flops; capture waits until the second flop holds a sampled level
  always_comb begin
    addr_idx = 4'(pin_a_s2_q) * 4'h3 + 4'(pin_b_s2_q);
    // level code 3 is not a strap option; keep the index inside the table
    if (addr_idx > 4'h8) addr_idx = 4'h8;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_a_s1_q   <= 2'h0;
      pin_a_s2_q   <= 2'h0;
      pin_b_s1_q   <= 2'h0;
      pin_b_s2_q   <= 2'h0;
      cap_wait_q   <= 2'h0;
      my_addr_q    <= 7'h00;
      addr_taken_q <= 1'b0;
    end else if (clk_en) begin
      pin_a_s1_q <= addr_select_pin_a;
      pin_a_s2_q <= pin_a_s1_q;
      pin_b_s1_q <= addr_select_pin_b;
      pin_b_s2_q <= pin_b_s1_q;
      if (cap_wait_q != 2'h2) begin
        cap_wait_q <= cap_wait_q + 2'h1;
      end else if (!addr_taken_q) begin
        my_addr_q    <= stl_pkg::ADDR_TABLE[addr_idx]; // R9 R10
        addr_taken_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // comparisons
  // ---------------------------------------------------------------
  logic signed [8:0] rem_adj;
  logic [4:0] trip;
  always_comb begin
    rem_adj = 9'($signed(remote_raw_temp)) + 9'($signed(offset_q)); // R4 R24
    // saturate so the corrected value stays in the eight-bit range
    if (rem_adj > 9'sd127) rem_adj = 9'sd127;
    if (rem_adj < -9'sd128) rem_adj = -9'sd128;
    trip[4] = $signed(local_temp) > $signed(lim_q[0]);   // R2 R3 R24
    trip[3] = $signed(local_temp) < $signed(lim_q[1]);   // R2 R3 R24
    trip[2] = rem_adj > 9'($signed(lim_q[2]));           // R2 R3 R24
    trip[1] = rem_adj < 9'($signed(lim_q[3]));           // R2 R3 R24
    trip[0] = sensor_open;
  end

  always_comb begin
    case (ptr_q) // R19 R20
      stl_pkg::RD_LOC_TEMP: rd_data = local_temp;
      stl_pkg::RD_REM_TEMP: rd_data = rem_adj[7:0];
      stl_pkg::RD_STATUS:   rd_data = {1'b0, flags_q, 2'b00};
      stl_pkg::RD_LOC_HIGH: rd_data = lim_q[0];
      stl_pkg::RD_LOC_LOW:  rd_data = lim_q[1];
      stl_pkg::RD_REM_HIGH: rd_data = lim_q[2];
      stl_pkg::RD_REM_LOW:  rd_data = lim_q[3];
      stl_pkg::REM_OFFSET:  rd_data = offset_q;
      default:              rd_data = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // protocol next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    shift_d   = shift_q;
    ptr_d     = ptr_q;
    bit_d     = bit_q;
    read_d    = read_q;
    pend_d    = pend_q;
    nbytes_d  = nbytes_q;
    lim_d     = lim_q;
    offset_d  = offset_q;
    sda_drv_d = sda_drv_q;
    shot_d    = 1'b0;
    // sticky flags: a new trip wins over a status-read clear
    flags_d   = flags_q | trip; // R22
    if (start_seen) begin
      state_d   = ST_ADDR; // R11
      bit_d     = 4'h0;
      nbytes_d  = 2'h0;
      sda_drv_d = 1'b0;
    end else if (stop_seen) begin
      state_d   = ST_IDLE;
      sda_drv_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: ;
        ST_ADDR, ST_RX: if (scl_rise) begin // R14
          shift_d = {shift_q[6:0], sda_s};
          bit_d   = bit_q + 4'h1;
        end else if (scl_fall && bit_q == 4'(stl_pkg::BITS_PER_BYTE)) begin
          bit_d = 4'h0;
          if (state_q == ST_ADDR) begin
            if (shift_q[7:1] == my_addr_q) begin
              read_d    = shift_q[0]; // R13 R16
              pend_d    = 1'b1;
              sda_drv_d = 1'b1; // R12
              state_d   = ST_ACK;
            end else begin
              state_d = ST_IDLE; // R12
            end
          end else if (nbytes_q == 2'h0) begin
            ptr_d     = shift_q; // R18 R23
            nbytes_d  = 2'h1;
            sda_drv_d = 1'b1;
            state_d   = ST_ACK;
          end else if (nbytes_q == 2'h1) begin
            nbytes_d  = 2'h2;
            sda_drv_d = 1'b1;
            state_d   = ST_ACK;
            case (ptr_q) // R1 R18 R20
              stl_pkg::WR_LOC_HIGH: lim_d[0] = shift_q;
              stl_pkg::WR_LOC_LOW:  lim_d[1] = shift_q;
              stl_pkg::WR_REM_HIGH: lim_d[2] = shift_q;
              stl_pkg::WR_REM_LOW:  lim_d[3] = shift_q;
              stl_pkg::REM_OFFSET:  offset_d = shift_q; // R4
              stl_pkg::WR_ONE_SHOT: shot_d   = standby; // R6 R7 R21
              default: ;
            endcase
          end else begin
            state_d = ST_SKIP; // R17
          end
        end
        ST_ACK: if (scl_fall) begin
          sda_drv_d = 1'b0;
          bit_d     = 4'h0;
          pend_d    = 1'b0;
          if (read_q && pend_q) begin
            state_d   = ST_TX;
            shift_d   = rd_data; // R19
            sda_drv_d = !rd_data[7];
            if (ptr_q == stl_pkg::RD_STATUS) flags_d = trip;
          end else begin
            state_d = ST_RX;
          end
        end
        ST_TX: if (scl_fall) begin
          bit_d = bit_q + 4'h1;
          if (bit_q == 4'(stl_pkg::BITS_PER_BYTE - 1)) begin
            sda_drv_d = 1'b0; // R15
            state_d   = ST_SKIP; // R17
          end else begin
            shift_d   = {shift_q[6:0], 1'b0};
            sda_drv_d = !shift_q[6];
          end
        end
        ST_SKIP: ;
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      shift_q   <= 8'h00;
      ptr_q     <= stl_pkg::RST_PTR;
      bit_q     <= 4'h0;
      read_q    <= 1'b0;
      pend_q    <= 1'b0;
      nbytes_q  <= 2'h0;
      lim_q     <= '{stl_pkg::RST_HIGH, stl_pkg::RST_LOW, stl_pkg::RST_HIGH, stl_pkg::RST_LOW};
      offset_q  <= stl_pkg::RST_OFFSET; // R5
      sda_drv_q <= 1'b0;
      flags_q   <= 5'h00;
      conv_start <= 1'b0;
    end else if (clk_en) begin
      state_q   <= state_d;
      shift_q   <= shift_d;
      ptr_q     <= ptr_d;
      bit_q     <= bit_d;
      read_q    <= read_d;
      pend_q    <= pend_d;
      nbytes_q  <= nbytes_d;
      lim_q     <= lim_d;
      offset_q  <= offset_d;
      sda_drv_q <= sda_drv_d;
      flags_q   <= flags_d;
      conv_start <= shot_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.sda_s_o  = 1'b0;
  assign link.sda_s_oe = sda_drv_q && powered; // R8
  assign alarm_n       = !(|flags_q); // R22
  assign status_flags  = {1'b0, flags_q, 2'b00};
endmodule

// [stl_pkg.sv]
// Contract
// (R1) four limit registers, bus readable and writable
// (R2) high alarm if greater, low if less
// (R3) limits hold and compare signed negative values
// (R4) eight-bit signed offset added to remote
// (R5) offset resets to zero, spans -128..127
// (R6) one-shot write in standby runs one conversion
// (R7) one-shot data byte discarded, never stored
// (R8) unpowered device never pulls bus lines
// (R9) address from two three-level pins
// (R10) address pins captured once after reset
// (R11) start, then seven address bits, direction
// (R12) matching slave acks, others stay idle
// (R13) direction zero writes, one reads
// (R14) nine clocks per byte, data moves low
// (R15) master ends with stop, nack on read
// (R16) direction fixed for whole operation
// (R17) writes one or two bytes, reads one
// (R18) first write byte loads pointer, second stores
// (R19) read returns register at current pointer
// (R20) separate read and write pointer values
// (R21) write pointer 0F is one-shot trigger
// (R22) any tripped flag drives alarm low
// (R23) pointer never auto-advances
// (R24) local vs local, remote plus offset vs remote
package stl_pkg;
  // ---------------------------------------------------------------
  // register pointers
  // ---------------------------------------------------------------
  localparam logic [7:0] RD_LOC_TEMP  = 8'h00;
  localparam logic [7:0] RD_REM_TEMP  = 8'h01;
  localparam logic [7:0] RD_STATUS    = 8'h02;
  localparam logic [7:0] RD_LOC_HIGH  = 8'h05;
  localparam logic [7:0] RD_LOC_LOW   = 8'h06;
  localparam logic [7:0] RD_REM_HIGH  = 8'h07;
  localparam logic [7:0] RD_REM_LOW   = 8'h08;
  localparam logic [7:0] WR_LOC_HIGH  = 8'h0B;
  localparam logic [7:0] WR_LOC_LOW   = 8'h0C;
  localparam logic [7:0] WR_REM_HIGH  = 8'h0D;
  localparam logic [7:0] WR_REM_LOW   = 8'h0E;
  localparam logic [7:0] WR_ONE_SHOT  = 8'h0F;
  localparam logic [7:0] REM_OFFSET   = 8'h11;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_HIGH     = 8'h7F;
  localparam logic [7:0] RST_LOW      = 8'hC9;
  localparam logic [7:0] RST_OFFSET   = 8'h00;
  localparam logic [7:0] RST_PTR      = 8'h00;
  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int ST_LHIGH = 6;
  localparam int ST_LLOW  = 5;
  localparam int ST_RHIGH = 4;
  localparam int ST_RLOW  = 3;
  localparam int ST_OPEN  = 2;
  // ---------------------------------------------------------------
  // pin levels and addresses, indexed pin_a*3 + pin_b
  // ---------------------------------------------------------------
  localparam logic [1:0] PIN_LOW  = 2'h0;
  localparam logic [1:0] PIN_OPEN = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;
  localparam logic [6:0] ADDR_TABLE [9] = '{7'h18, 7'h19, 7'h1A, 7'h29, 7'h2A,
                                             7'h2B, 7'h4C, 7'h4D, 7'h4E};
  localparam int BITS_PER_BYTE = 8;
  // ---------------------------------------------------------------
  // link timing: LINK_PERIOD_NS is half the bit period of the master's clock
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int LINK_PERIOD_NS = 10000;
  localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

// [stl_link_if.sv]
interface stl_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  // open drain: any enabled low driver pulls the wire low
  wire  scl              = !(scl_oe && !scl_o);
  wire  serial_data_line = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport device (input scl, input serial_data_line, output sda_s_o, output sda_s_oe);
  modport master (input scl, input serial_data_line, output scl_o, output scl_oe,
                  output sda_m_o, output sda_m_oe);
endinterface

// [stl_master.sv]
module stl_master #(
  parameter int HALF_CYC = stl_pkg::LINK_HALF_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       req_valid,
  input  wire logic       req_read,
  input  wire logic       req_two,
  input  wire logic [6:0] req_addr,
  input  wire logic [7:0] req_ptr,
  input  wire logic [7:0] req_data,
  output logic            req_ready,
  output logic            done,
  output logic            nack,
  output logic [7:0]      rd_data,
  stl_link_if.master      link
);
  typedef enum logic [3:0] {
    M_IDLE = 4'h1, M_START = 4'h2, M_BITS = 4'h4, M_STOP = 4'h8
  } stl_mstate_type;

  logic [1:0] sda_sync_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) sda_sync_q <= 2'h3;
    else if (clk_en) sda_sync_q <= {sda_sync_q[0], link.serial_data_line};
  end

  stl_mstate_type st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [1:0]  ph_q, ph_d;
  logic [3:0]  bit_q, bit_d;
  logic [1:0]  byte_q, byte_d, nbytes_q, nbytes_d;
  logic [8:0]  sh_q, sh_d;
  logic [7:0]  rx_q, rx_d;
  logic        scl_q, scl_d, sda_q, sda_d, rd_q, rd_d, done_d, nack_q, nack_d;
  logic [7:0]  dat1_q, dat1_d, dat2_q, dat2_d;

  wire tick = (cnt_q == 16'(HALF_CYC - 1));
  always_comb begin
    st_d = st_q; cnt_d = tick ? 16'h0000 : cnt_q + 16'h0001;
    ph_d = ph_q; bit_d = bit_q; byte_d = byte_q; nbytes_d = nbytes_q;
    sh_d = sh_q; rx_d = rx_q; scl_d = scl_q; sda_d = sda_q; rd_d = rd_q;
    done_d = 1'b0; nack_d = nack_q; dat1_d = dat1_q; dat2_d = dat2_q;
    case (st_q)
      M_IDLE: begin
        cnt_d = 16'h0000;
        if (req_valid) begin
          st_d = M_START; rd_d = req_read; nack_d = 1'b0; // R16
          nbytes_d = req_read ? 2'h1 : (req_two ? 2'h2 : 2'h1); // R17
          sh_d = {req_addr, req_read, 1'b1}; dat1_d = req_ptr; dat2_d = req_data;
        end
      end
      M_START: if (tick) begin
        sda_d = 1'b0; st_d = M_BITS; ph_d = 2'h0; bit_d = 4'h0; byte_d = 2'h0; // R11
      end
      M_BITS: if (tick) begin
        ph_d = ph_q + 2'h1;
        case (ph_q)
          2'h0: begin scl_d = 1'b0; end
          2'h1: begin sda_d = sh_q[8]; end // R14
          2'h2: begin scl_d = 1'b1; end
          default: begin
            sh_d = {sh_q[7:0], 1'b1}; rx_d = {rx_q[6:0], sda_sync_q[1]};
            bit_d = bit_q + 4'h1;
            if (bit_q == 4'h8) begin
              bit_d = 4'h0;
              if (!rd_q) nack_d = nack_q | sda_sync_q[1];
              if (byte_q == 2'h0 && sda_sync_q[1]) begin
                nack_d = 1'b1; st_d = M_STOP; ph_d = 2'h0;
              end else if (byte_q == nbytes_q) begin
                st_d = M_STOP; ph_d = 2'h0;
              end else begin
                sh_d = rd_q ? 9'h1FF : {(byte_q == 2'h0 ? dat1_q : dat2_q), 1'b1}; // R15
                byte_d = byte_q + 2'h1;
              end
              if (rd_q && byte_q == 2'h1) rx_d = rx_q;
            end
          end
        endcase
      end
      M_STOP: if (tick) begin
        ph_d = ph_q + 2'h1;
        case (ph_q)
          2'h0: scl_d = 1'b0;
          2'h1: sda_d = 1'b0;
          2'h2: scl_d = 1'b1;
          default: begin sda_d = 1'b1; st_d = M_IDLE; done_d = 1'b1; end // R15
        endcase
      end
      default: st_d = M_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= M_IDLE; cnt_q <= 16'h0000; ph_q <= 2'h0; bit_q <= 4'h0;
      byte_q <= 2'h0; nbytes_q <= 2'h0; sh_q <= 9'h1FF; rx_q <= 8'h00;
      scl_q <= 1'b1; sda_q <= 1'b1; rd_q <= 1'b0; done <= 1'b0; nack_q <= 1'b0;
      dat1_q <= 8'h00; dat2_q <= 8'h00; rd_data <= 8'h00;
    end else if (clk_en) begin
      st_q <= st_d; cnt_q <= cnt_d; ph_q <= ph_d; bit_q <= bit_d;
      byte_q <= byte_d; nbytes_q <= nbytes_d; sh_q <= sh_d; rx_q <= rx_d;
      scl_q <= scl_d; sda_q <= sda_d; rd_q <= rd_d; done <= done_d; nack_q <= nack_d;
      dat1_q <= dat1_d; dat2_q <= dat2_d;
      if (done_d && rd_q) rd_data <= rx_q;
    end
  end

  assign req_ready     = (st_q == M_IDLE);
  assign nack          = nack_q;
  assign link.scl_o    = scl_q;
  assign link.scl_oe   = 1'b1;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = !sda_q;
endmodule

// [stl_link_monitor.sv]
module stl_link_monitor #(
  parameter int HALF_CYC = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic serial_data_line,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ack plus eight zero data bits can keep the slave pulling for nine bit periods
  localparam int HOLD_MAX = 9 * 4 * HALF_CYC + 8;
  logic [5:0]  bit_cnt_q;
  logic [5:0]  bit_cnt_d;
  logic [15:0] low_cnt_q;
  logic [15:0] low_cnt_d;
  logic        scl_q;
  logic        sda_q;
  // ---------------------------------------------------------------
  // clock rises since the last start, and cycles the clock has been low
  // ---------------------------------------------------------------
  always_comb begin
    bit_cnt_d = bit_cnt_q;
    if (scl && scl_q && sda_q && !serial_data_line) begin
      bit_cnt_d = 6'h00;
    end else if (scl && !scl_q && bit_cnt_q != 6'h3F) begin
      bit_cnt_d = bit_cnt_q + 6'h01;
    end
    low_cnt_d = scl ? 16'h0000 : low_cnt_q + 16'h0001;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_cnt_q <= 6'h00;
      low_cnt_q <= 16'h0000;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      low_cnt_q <= low_cnt_d;
      scl_q     <= scl;
      sda_q     <= serial_data_line;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence start_seq;
    scl && $past(scl) && $fell(serial_data_line);
  endsequence
  sequence stop_seq;
    scl && $past(scl) && $rose(serial_data_line);
  endsequence
  a_slave_pull_only: assert property (sda_s_oe |-> !sda_s_o)
    else $error("slave drives the data line high");
  a_slave_edge_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave moved data while clock high");
  a_ack_slot: assert property ($rose(sda_s_oe) |-> bit_cnt_q inside {[8:17], 26})
    else $error("slave drive began outside an ack or read slot");
  a_slave_release: assert property ($rose(sda_s_oe) |-> ##[1:HOLD_MAX] !sda_s_oe)
    else $error("slave held the data line too long");
  a_master_frames: assert property (scl && $past(scl) && $changed(serial_data_line)
                                    |-> $changed({sda_m_o, sda_m_oe}))
    else $error("data changed under high clock without the master");
  a_start_clock: assert property (start_seq |-> ##[1:40] !scl)
    else $error("no clock after start");
  a_stop_idle: assert property (stop_seq |-> (scl && serial_data_line) [*2])
    else $error("bus not idle after stop");
  a_low_phase: assert property (low_cnt_q <= 4 * HALF_CYC)
    else $error("clock low phase too long");
endmodule

// [smbus_temp_limit_reg_slave_tb.sv]
module smbus_temp_limit_reg_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 8;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       clk_en = 1'b1;
  logic       powered = 1'b1;
  logic       standby = 1'b0;
  logic       sensor_open = 1'b0;
  logic [1:0] pin_a = 2'h0;
  logic [1:0] pin_b = 2'h0;
  logic [7:0] local_temp = 8'h19;
  logic [7:0] remote_raw = 8'h12;
  logic       req_valid = 1'b0;
  logic       req_read = 1'b0;
  logic       req_two = 1'b0;
  logic [6:0] req_addr = 7'h00;
  logic [7:0] req_ptr = 8'h00;
  logic [7:0] req_data = 8'h00;
  logic [6:0] dev = 7'h18;
  logic [7:0] conv_cnt = 8'h00;
  logic       conv_start, alarm_n, req_ready, done, nack;
  logic [7:0] status_flags, rd_data, v;
  int         num_errors = 0;
  int         check_count = 0;
  stl_link_if link_bus ();
  stl_device u_stl_device (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .powered(powered),
    .addr_select_pin_a(pin_a), .addr_select_pin_b(pin_b), .standby(standby), .local_temp(local_temp),
    .remote_raw_temp(remote_raw), .sensor_open(sensor_open), .conv_start(conv_start),
    .alarm_n(alarm_n), .status_flags(status_flags), .link(link_bus));
  stl_master #(.HALF_CYC(HALF)) u_stl_master (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .req_valid(req_valid), .req_read(req_read), .req_two(req_two), .req_addr(req_addr),
    .req_ptr(req_ptr), .req_data(req_data), .req_ready(req_ready), .done(done), .nack(nack),
    .rd_data(rd_data), .link(link_bus));
  stl_link_monitor #(.HALF_CYC(HALF)) u_stl_link_monitor (.sys_clk(sys_clk), .rst(rst),
    .scl(link_bus.scl), .serial_data_line(link_bus.serial_data_line), .sda_m_o(link_bus.sda_m_o),
    .sda_m_oe(link_bus.sda_m_oe), .sda_s_o(link_bus.sda_s_o), .sda_s_oe(link_bus.sda_s_oe));
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (conv_start === 1'b1) conv_cnt <= conv_cnt + 8'h01;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apply_reset();
    rst = 1'b1;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic req(input logic rd, input logic two, input logic [6:0] a, input logic [7:0] p,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    {req_valid, req_read, req_two, req_addr, req_ptr, req_data} = {1'b1, rd, two, a, p, d};
    while (req_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    @(negedge sys_clk);
    req_valid = 1'b0;
    while (done !== 1'b1 && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 5000) check(8'h00, 8'h01);
  endtask
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
    req(1'b0, 1'b1, dev, p, d);
  endtask
  task automatic rd_reg(input logic [7:0] p);
    req(1'b0, 1'b0, dev, p, 8'h00);
    req(1'b1, 1'b0, dev, 8'h00, 8'h00);
    v = rd_data;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_values();
    logic [7:0] exp [5] = '{8'h7F, 8'hC9, 8'h7F, 8'hC9, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rd_reg(i < 4 ? 8'h05 + 8'(i) : 8'h11);
      check(v, exp[i]);
    end
  endtask
  task automatic t_offset();
    logic [7:0] off [5] = '{8'hFC, 8'hFF, 8'h00, 8'h01, 8'h04};
    logic [7:0] exp [5] = '{8'h0E, 8'h11, 8'h12, 8'h13, 8'h16};
    for (int i = 0; i < 5; i++) begin
      wr_reg(8'h11, off[i]);
      rd_reg(8'h01);
      check(v, exp[i]);
    end
  endtask
  task automatic t_compare();
    wr_reg(8'h0B, 8'h50);
    wr_reg(8'h0C, 8'hF0);
    wr_reg(8'h0D, 8'h20);
    wr_reg(8'h11, 8'h04);
    {local_temp, remote_raw} = {8'h50, 8'h1C};
    repeat (8) @(negedge sys_clk);
    local_temp = 8'hF0;
    repeat (8) @(negedge sys_clk);
    check(status_flags, 8'h00);
    check({7'h00, alarm_n}, 8'h01);
    clk_en = 1'b0;
    local_temp = 8'h51;
    repeat (8) @(negedge sys_clk);
    check(status_flags, 8'h00);
    clk_en = 1'b1;
    repeat (8) @(negedge sys_clk);
    check(status_flags, 8'h40);
    check({7'h00, alarm_n}, 8'h00);
    local_temp = 8'hEF;
    repeat (8) @(negedge sys_clk);
    check(status_flags, 8'h60);
    remote_raw = 8'h1D;
    repeat (8) @(negedge sys_clk);
    check(status_flags, 8'h70);
    {local_temp, remote_raw} = {8'h19, 8'h12};
    rd_reg(8'h02);
    check(v, 8'h70);
    repeat (8) @(negedge sys_clk);
    check({status_flags[7:1], alarm_n}, 8'h01);
    sensor_open = 1'b1;
    repeat (8) @(negedge sys_clk);
    check(status_flags, 8'h04);
    sensor_open = 1'b0;
    rd_reg(8'h02);
    check(v, 8'h04);
    check({7'h00, alarm_n}, 8'h01);
  endtask
  task automatic t_one_shot();
    logic [7:0] c0;
    standby = 1'b1;
    c0 = conv_cnt;
    wr_reg(8'h0F, 8'hA5);
    repeat (4) @(negedge sys_clk);
    check(conv_cnt - c0, 8'h01);
    rd_reg(8'h0F);
    check(v, 8'h00);
    standby = 1'b0;
    wr_reg(8'h0F, 8'h5A);
    repeat (4) @(negedge sys_clk);
    check(conv_cnt - c0, 8'h01);
  endtask
  task automatic t_limits_rw();
    logic [7:0] val [4] = '{8'h80, 8'hF6, 8'h9C, 8'hC0};
    for (int i = 0; i < 4; i++) wr_reg(8'h0B + 8'(i), val[i]);
    for (int i = 0; i < 4; i++) begin
      rd_reg(8'h05 + 8'(i));
      check(v, val[i]);
    end
    req(1'b1, 1'b0, dev, 8'h00, 8'h00);
    check(rd_data, val[3]);
    check({7'h00, nack}, 8'h00);
    rd_reg(8'h0B);
    check(v, 8'h00);
  endtask
  task automatic t_unpowered();
    powered = 1'b0;
    req(1'b0, 1'b0, dev, 8'h00, 8'h00);
    check({7'h00, nack}, 8'h01);
    powered = 1'b1;
  endtask
  task automatic t_address();
    logic [6:0] tab [9] = '{7'h18, 7'h19, 7'h1A, 7'h29, 7'h2A, 7'h2B, 7'h4C, 7'h4D, 7'h4E};
    for (int i = 0; i < 9; i++) begin
      {pin_a, pin_b} = {2'(i / 3), 2'(i % 3)};
      apply_reset();
      req(1'b0, 1'b0, tab[i], 8'h00, 8'h00);
      check({7'h00, nack}, 8'h00);
      pin_a = 2'((i / 3 + 1) % 3);
      req(1'b0, 1'b0, tab[i], 8'h00, 8'h00);
      check({7'h00, nack}, 8'h00);
      req(1'b0, 1'b0, tab[i] ^ 7'h40, 8'h00, 8'h00);
      check({7'h00, nack}, 8'h01);
    end
  endtask
  initial begin
    apply_reset();
    t_reset_values();
    t_offset();
    t_compare();
    t_one_shot();
    t_limits_rw();
    t_unpowered();
    t_address();
    results();
  end
  initial begin
    #700000;
    num_errors++;
    results();
  end
endmodule
